// ---- core/video_preamp_control_registers.sv ----
// Purpose: Control register bank of a three-channel video preamplifier.
// Assumes: The serial engine hands over sub-address, data and a completion strobe.
// Notes: One clock; all outputs are flop outputs and hold their power-on values at reset.
`timescale 1ns/100ps
module video_preamp_control_registers (
  // Clock of the whole bank.
  input wire logic CLOCK,
  // Asynchronous active-low reset.
  input wire logic RST_N,
  // Sub-address of the current or last serial access.
  input wire logic [7:0] SUB_ADDR,
  // Data byte of a write.
  input wire logic [7:0] WR_DATA,
  // One-cycle pulse when a serial write has completed.
  input wire logic WR_STROBE,
  // Read-back of the register at SUB_ADDR.
  output logic [7:0] RD_DATA,
  // Contrast gain code.
  output logic [7:0] CONTRAST_CODE,
  // Brightness level code.
  output logic [7:0] BRIGHTNESS_CODE,
  // Per-channel gain codes.
  output logic [7:0] CHANNEL_ONE_CODE,
  output logic [7:0] CHANNEL_TWO_CODE,
  output logic [7:0] CHANNEL_THREE_CODE,
  // Output offset level code.
  output logic [3:0] OUTPUT_LEVEL_CODE,
  // Overlay gain code.
  output logic [3:0] OVERLAY_GAIN_CODE,
  // Raw clamp and misc byte.
  output logic [7:0] MISC_CODE,
  // Clamp reference: high means the blanking input.
  output logic CLAMP_FROM_BLANKING,
  // Clamp pulse width in clock cycles.
  output logic [8:0] CLAMP_WIDTH_CYCLES,
  // Soft blanking on.
  output logic SOFT_BLANK_ON,
  // Soft blanking field holds a test pattern.
  output logic SOFT_BLANK_TEST,
  // Semi-transparent overlay background on.
  output logic SEMI_TRANSPARENT_ON,
  // Blanking input polarity: high means negative.
  output logic BLANKING_NEGATIVE,
  // Level register holds a code the analog stage cannot use.
  output logic LEVEL_CODE_INVALID,
  // One-cycle pulse: a write has landed in a register.
  output logic WRITE_DONE,
  // One-cycle pulse: a write named an unmapped sub-address.
  output logic WRITE_MISSED
);

  // Register contents, indexed by sub-address minus one.
  wire logic [7:0] reg_val [0:preamp_regs_pkg::NUM_REGS-1];

  // Per-register load strobes.
  wire logic [preamp_regs_pkg::NUM_REGS-1:0] load_vec;

  // Address decode of the current sub-address.
  wire logic addr_in_map;
  wire logic [2:0] addr_index;

  // A write is accepted only when the strobe meets a mapped address.
  wire logic write_hit;
  wire logic write_miss;

  // Read-back value chosen for the current sub-address.
  wire logic [7:0] rd_value;

  // Level-code check of an incoming level write.
  wire logic level_write;
  wire logic level_bad_new;

  // Decoded soft blanking mode from the misc decoder.
  preamp_regs_pkg::soft_mode_t soft_mode;

  // Flop state owned by this module.
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic level_bad_q;
  logic level_bad_d;
  logic write_done_q;
  logic write_missed_q;
  logic soft_on_q;
  logic soft_test_q;

  // Decode uses the package helpers so the range check lives in one place.
  assign addr_in_map = preamp_regs_pkg::addr_hit(SUB_ADDR);
  assign addr_index = preamp_regs_pkg::index_of(SUB_ADDR);

  // Only the completion strobe may move a register; stray addresses do nothing.
  assign write_hit = WR_STROBE && addr_in_map;
  assign write_miss = WR_STROBE && !addr_in_map;

  // Each register owns one fixed slot of the map.
  genvar gi;
  generate
    for (gi = 0; gi < preamp_regs_pkg::NUM_REGS; gi = gi + 1) begin : g_load
      assign load_vec[gi] = write_hit && (addr_index == 3'(gi));
    end
  endgenerate

  // The eight storage cells. Reset values and write masks come from the
  // package by index, so each cell is independent of its neighbours and the
  // nibble registers drop the high half of a written byte.
  generate
    for (gi = 0; gi < preamp_regs_pkg::NUM_REGS; gi = gi + 1) begin : g_reg
      ctrl_reg #(
        .RESET_VALUE(preamp_regs_pkg::reset_of(gi)),
        .KEEP_MASK(preamp_regs_pkg::mask_of(gi))
      ) u_reg (
        .clk(CLOCK),
        .rst_n(RST_N),
        .load(load_vec[gi]),
        .din(WR_DATA),
        .q(reg_val[gi])
      );
    end
  endgenerate

  // Register codes go straight from the storage flops to the converters.
  // The contrast code is handed over unchanged: the converter applies one
  // binary weight per bit, so no remapping is wanted here.
  assign CONTRAST_CODE = reg_val[0];
  assign BRIGHTNESS_CODE = reg_val[1];
  assign CHANNEL_ONE_CODE = reg_val[2];
  assign CHANNEL_TWO_CODE = reg_val[3];
  assign CHANNEL_THREE_CODE = reg_val[4];
  assign OUTPUT_LEVEL_CODE = reg_val[preamp_regs_pkg::IDX_OUTPUT_LEVEL][3:0];
  assign OVERLAY_GAIN_CODE = reg_val[preamp_regs_pkg::IDX_OVERLAY][3:0];
  assign MISC_CODE = reg_val[preamp_regs_pkg::IDX_MISC];

  // Decoded misc fields, registered in the decoder.
  misc_decode u_misc (
    .clk(CLOCK),
    .rst_n(RST_N),
    .misc(reg_val[preamp_regs_pkg::IDX_MISC]),
    .clamp_from_blanking(CLAMP_FROM_BLANKING),
    .clamp_width_cycles(CLAMP_WIDTH_CYCLES),
    .soft_mode(soft_mode),
    .semi_transparent(SEMI_TRANSPARENT_ON),
    .blanking_negative(BLANKING_NEGATIVE)
  );

  // Read-back selection. Unmapped sub-addresses read as zero so the serial
  // engine always has a defined byte to shift out.
  assign rd_value = addr_in_map ? reg_val[addr_index] : 8'h00;

  // Read data follows the sub-address one cycle later.
  always_comb begin
    rd_data_d = rd_value;
  end

  // The level check looks at the nibble that will actually be stored.
  assign level_write = load_vec[preamp_regs_pkg::IDX_OUTPUT_LEVEL];
  assign level_bad_new = WR_DATA[3:0] < preamp_regs_pkg::LEVEL_MIN_VALID;

  // The flag tracks the stored code, so a later good write clears it.
  // Nothing stops the bad code from loading: the master alone keeps
  // this range, and the flag only lets a supervisor notice a slip.
  always_comb begin
    if (level_write) begin
      level_bad_d = level_bad_new;
    end else begin
      level_bad_d = level_bad_q;
    end
  end

  // Read data flop.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // Level flag flop; the power-on code is valid, so it starts low.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      level_bad_q <= 1'b0;
    end else begin
      level_bad_q <= level_bad_d;
    end
  end

  // Write outcome pulses, one cycle after the strobe.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      write_done_q <= 1'b0;
      write_missed_q <= 1'b0;
    end else begin
      write_done_q <= write_hit;
      write_missed_q <= write_miss;
    end
  end

  // Soft blanking mode split into two plain levels. Test patterns leave
  // blanking in neither clean state, so they are flagged apart.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      soft_on_q <= 1'b0;
      soft_test_q <= 1'b0;
    end else begin
      case (soft_mode)
        preamp_regs_pkg::SOFT_ENABLED: begin
          soft_on_q <= 1'b1;
          soft_test_q <= 1'b0;
        end
        preamp_regs_pkg::SOFT_DISABLED: begin
          soft_on_q <= 1'b0;
          soft_test_q <= 1'b0;
        end
        default: begin
          soft_on_q <= 1'b0;
          soft_test_q <= 1'b1;
        end
      endcase
    end
  end

  // Flop outputs.
  assign RD_DATA = rd_data_q;
  assign LEVEL_CODE_INVALID = level_bad_q;
  assign WRITE_DONE = write_done_q;
  assign WRITE_MISSED = write_missed_q;
  assign SOFT_BLANK_ON = soft_on_q;
  assign SOFT_BLANK_TEST = soft_test_q;

endmodule : video_preamp_control_registers

// ---- common/preamp_regs_pkg.sv ----
// Purpose: Shared constants, types and helpers of the preamp control register bank.
// Assumes: One 200 MHz clock; sub-addresses arrive already decoded from the serial engine.
// Notes: Every offset, reset value, field position and timing count is named here once.
package preamp_regs_pkg;

  // Sub-addresses of the eight control registers.
  localparam logic [7:0] ADDR_CONTRAST = 8'h01;
  localparam logic [7:0] ADDR_BRIGHTNESS = 8'h02;
  localparam logic [7:0] ADDR_CHANNEL_ONE = 8'h03;
  localparam logic [7:0] ADDR_CHANNEL_TWO = 8'h04;
  localparam logic [7:0] ADDR_CHANNEL_THREE = 8'h05;
  localparam logic [7:0] ADDR_OUTPUT_LEVEL = 8'h06;
  localparam logic [7:0] ADDR_OVERLAY = 8'h07;
  localparam logic [7:0] ADDR_MISC = 8'h08;
  localparam int NUM_REGS = 8;

  // Register indices (sub-address minus one) of the narrow and mixed registers.
  localparam int IDX_OUTPUT_LEVEL = 5;
  localparam int IDX_OVERLAY = 6;
  localparam int IDX_MISC = 7;

  // Power-on values.
  localparam logic [7:0] RST_GAIN = 8'hB4;
  localparam logic [7:0] RST_NIBBLE = 8'h08;
  localparam logic [7:0] RST_MISC = 8'h04;

  // Bits kept on a write: full byte or low nibble only.
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_NIBBLE = 8'h0F;

  // Lowest output level code that the analog stage accepts.
  localparam logic [3:0] LEVEL_MIN_VALID = 4'h3;

  // Field positions inside the miscellaneous register.
  localparam int MISC_CLAMP_SRC_BIT = 0;
  localparam int MISC_WIDTH_LSB = 1;
  localparam int MISC_WIDTH_MSB = 2;
  localparam int MISC_SOFT_LSB = 3;
  localparam int MISC_SOFT_MSB = 5;
  localparam int MISC_SEMI_BIT = 6;
  localparam int MISC_POLARITY_BIT = 7;

  // Soft blanking field patterns.
  localparam logic [2:0] SOFT_PATTERN_OFF = 3'h0;
  localparam logic [2:0] SOFT_PATTERN_ON = 3'h7;

  // Clamp pulse widths in ns, and in clock cycles rounded up.
  localparam int CLOCK_MHZ = 200;
  localparam int CLAMP_W0_NS = 330;
  localparam int CLAMP_W1_NS = 660;
  localparam int CLAMP_W2_NS = 1000;
  localparam int CLAMP_W3_NS = 1300;
  localparam int CLAMP_W0_CYC = (CLAMP_W0_NS * CLOCK_MHZ + 999) / 1000;
  localparam int CLAMP_W1_CYC = (CLAMP_W1_NS * CLOCK_MHZ + 999) / 1000;
  localparam int CLAMP_W2_CYC = (CLAMP_W2_NS * CLOCK_MHZ + 999) / 1000;
  localparam int CLAMP_W3_CYC = (CLAMP_W3_NS * CLOCK_MHZ + 999) / 1000;
  localparam int CYC_W = 9;

  // Soft blanking mode as seen by the analog side.
  typedef enum logic [1:0] {SOFT_DISABLED, SOFT_ENABLED, SOFT_TEST} soft_mode_t;

  // Power-on value of a register by index.
  function automatic logic [7:0] reset_of(input int idx);
    if (idx == IDX_MISC) return RST_MISC;
    if (idx == IDX_OUTPUT_LEVEL || idx == IDX_OVERLAY) return RST_NIBBLE;
    return RST_GAIN;
  endfunction : reset_of

  // Write mask of a register by index.
  function automatic logic [7:0] mask_of(input int idx);
    if (idx == IDX_OUTPUT_LEVEL || idx == IDX_OVERLAY) return MASK_NIBBLE;
    return MASK_FULL;
  endfunction : mask_of

  // True when a sub-address names one of the eight registers.
  function automatic logic addr_hit(input logic [7:0] addr);
    return (addr >= ADDR_CONTRAST) && (addr <= ADDR_MISC);
  endfunction : addr_hit

  // Register index of a mapped sub-address.
  function automatic logic [2:0] index_of(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - ADDR_CONTRAST;
    return diff[2:0];
  endfunction : index_of

  // Clamp width in cycles for a two-bit width selection.
  function automatic logic [CYC_W-1:0] width_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: return CYC_W'(CLAMP_W0_CYC);
      2'h1: return CYC_W'(CLAMP_W1_CYC);
      2'h2: return CYC_W'(CLAMP_W2_CYC);
      default: return CYC_W'(CLAMP_W3_CYC);
    endcase
  endfunction : width_cycles

  // Soft blanking mode for a three-bit field.
  function automatic soft_mode_t soft_mode_of(input logic [2:0] field);
    if (field == SOFT_PATTERN_OFF) return SOFT_DISABLED;
    if (field == SOFT_PATTERN_ON) return SOFT_ENABLED;
    return SOFT_TEST;
  endfunction : soft_mode_of

endpackage : preamp_regs_pkg

// ---- core/ctrl_reg.sv ----
// Purpose: One control register with a load strobe and a write mask.
// Assumes: Load is a one-cycle pulse marking a completed serial write.
// Notes: Masked bits always read zero, so narrow codes never see stray high bits.
`timescale 1ns/100ps
module ctrl_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] KEEP_MASK = 8'hFF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] din,
  output logic [7:0] q
);

  // The stored value is only replaced on a completed write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VALUE;
    end else if (load) begin
      q <= din & KEEP_MASK;
    end
  end

endmodule : ctrl_reg

// ---- core/misc_decode.sv ----
// Purpose: Registered decode of the clamp and miscellaneous control byte.
// Assumes: The byte comes from a register flop in the same clock domain.
// Notes: Outputs trail the byte by one cycle and reset to the decode of its power-on value.
`timescale 1ns/100ps
module misc_decode (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] misc,
  output logic clamp_from_blanking,
  output logic [preamp_regs_pkg::CYC_W-1:0] clamp_width_cycles,
  output preamp_regs_pkg::soft_mode_t soft_mode,
  output logic semi_transparent,
  output logic blanking_negative
);

  // Reset decode, taken from the same functions as the live decode.
  localparam logic [1:0] RST_WSEL =
    preamp_regs_pkg::RST_MISC[preamp_regs_pkg::MISC_WIDTH_MSB:preamp_regs_pkg::MISC_WIDTH_LSB];
  localparam logic [2:0] RST_SOFT =
    preamp_regs_pkg::RST_MISC[preamp_regs_pkg::MISC_SOFT_MSB:preamp_regs_pkg::MISC_SOFT_LSB];

  // Field slices of the live byte.
  wire logic [1:0] width_sel;
  wire logic [2:0] soft_field;
  assign width_sel = misc[preamp_regs_pkg::MISC_WIDTH_MSB:preamp_regs_pkg::MISC_WIDTH_LSB];
  assign soft_field = misc[preamp_regs_pkg::MISC_SOFT_MSB:preamp_regs_pkg::MISC_SOFT_LSB];

  // Register every decoded field so the analog side sees clean levels.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clamp_from_blanking <= preamp_regs_pkg::RST_MISC[preamp_regs_pkg::MISC_CLAMP_SRC_BIT];
      clamp_width_cycles <= preamp_regs_pkg::width_cycles(RST_WSEL);
      soft_mode <= preamp_regs_pkg::soft_mode_of(RST_SOFT);
      semi_transparent <= preamp_regs_pkg::RST_MISC[preamp_regs_pkg::MISC_SEMI_BIT];
      blanking_negative <= preamp_regs_pkg::RST_MISC[preamp_regs_pkg::MISC_POLARITY_BIT];
    end else begin
      clamp_from_blanking <= misc[preamp_regs_pkg::MISC_CLAMP_SRC_BIT];
      clamp_width_cycles <= preamp_regs_pkg::width_cycles(width_sel);
      soft_mode <= preamp_regs_pkg::soft_mode_of(soft_field);
      semi_transparent <= misc[preamp_regs_pkg::MISC_SEMI_BIT];
      blanking_negative <= misc[preamp_regs_pkg::MISC_POLARITY_BIT];
    end
  end

endmodule : misc_decode

// ---- dv/preamp_regs_checker.sv ----
// Purpose: Port-level assertions for the preamp control register bank.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Decoded misc outputs are judged against the byte they trail.
`timescale 1ns/100ps
module preamp_regs_checker (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] SUB_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_STROBE,
  input wire logic [7:0] CONTRAST_CODE,
  input wire logic [7:0] CHANNEL_ONE_CODE,
  input wire logic [7:0] CHANNEL_TWO_CODE,
  input wire logic [3:0] OUTPUT_LEVEL_CODE,
  input wire logic [3:0] OVERLAY_GAIN_CODE,
  input wire logic [7:0] MISC_CODE,
  input wire logic CLAMP_FROM_BLANKING,
  input wire logic [8:0] CLAMP_WIDTH_CYCLES,
  input wire logic SOFT_BLANK_ON,
  input wire logic SEMI_TRANSPARENT_ON,
  input wire logic BLANKING_NEGATIVE,
  input wire logic WRITE_DONE,
  input wire logic WRITE_MISSED
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // High when the sub-address names one of the eight registers.
  wire mapped = (SUB_ADDR >= 8'h01) && (SUB_ADDR <= 8'h08);
  // Clamp width in cycles per select, rounded up at 200 MHz.
  function automatic logic [8:0] width_of(input logic [1:0] sel);
    return (sel == 2'h0) ? 9'h042 : (sel == 2'h1) ? 9'h084 : (sel == 2'h2) ? 9'h0C8 : 9'h104;
  endfunction : width_of
  chk_write_done_pulse: assert property (WR_STROBE && mapped |=> WRITE_DONE && !WRITE_MISSED)
    else $error("write done pulse missing");
  chk_unmapped_ignored: assert property (WR_STROBE && !mapped |=> WRITE_MISSED && !WRITE_DONE
    && $stable(CONTRAST_CODE) && $stable(MISC_CODE))
    else $error("unmapped write changed state");
  chk_idle_holds: assert property (!WR_STROBE |=> $stable(CONTRAST_CODE) && $stable(MISC_CODE)
    && $stable(OUTPUT_LEVEL_CODE) && !WRITE_DONE && !WRITE_MISSED)
    else $error("register moved without a write");
  chk_contrast_load: assert property (WR_STROBE && SUB_ADDR == 8'h01 |=>
    CONTRAST_CODE == $past(WR_DATA))
    else $error("contrast not loaded");
  chk_channel_separate: assert property (WR_STROBE && SUB_ADDR == 8'h03 |=>
    CHANNEL_ONE_CODE == $past(WR_DATA) && $stable(CHANNEL_TWO_CODE))
    else $error("channel gains not independent");
  chk_level_nibble: assert property (WR_STROBE && SUB_ADDR == 8'h06 |=>
    OUTPUT_LEVEL_CODE == $past(WR_DATA[3:0]))
    else $error("level nibble wrong");
  chk_overlay_nibble: assert property (WR_STROBE && SUB_ADDR == 8'h07 |=>
    OVERLAY_GAIN_CODE == $past(WR_DATA[3:0]))
    else $error("overlay nibble wrong");
  chk_clamp_source: assert property (CLAMP_FROM_BLANKING == $past(MISC_CODE[0]))
    else $error("clamp source decode wrong");
  chk_clamp_width: assert property (CLAMP_WIDTH_CYCLES == width_of($past(MISC_CODE[2:1])))
    else $error("clamp width decode wrong");
  chk_soft_blank: assert property (SOFT_BLANK_ON == ($past(MISC_CODE[5:3], 2) == 3'h7))
    else $error("soft blanking decode wrong");
  chk_overlay_polarity: assert property (SEMI_TRANSPARENT_ON == $past(MISC_CODE[6])
    && BLANKING_NEGATIVE == $past(MISC_CODE[7]))
    else $error("semi or polarity decode wrong");
endmodule : preamp_regs_checker

// ---- dv/serial_master_model.sv ----
// Purpose: Behavioural serial bus master handing completed writes to the bank.
// Assumes: Drives on the falling edge so the bank samples settled values.
// Notes: Data not qualified by the strobe is inverted, so stale bytes never look valid.
`timescale 1ns/100ps
module serial_master_model (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  output logic [7:0] sub_addr,
  output logic [7:0] wr_data,
  output logic wr_strobe
);
  // Quiet bus at time zero.
  initial begin
    sub_addr = 8'h00;
    wr_data = 8'h00;
    wr_strobe = 1'b0;
  end
  // One completed write; a low level code is sent only when a test asks for it.
  task automatic write(input logic [7:0] addr, input logic [7:0] data, input bit bad_ok);
    if (addr == 8'h06 && data[3:0] < 4'h3 && !bad_ok) return;
    @(negedge clk);
    sub_addr = addr;
    wr_data = data;
    wr_strobe = 1'b1;
    @(negedge clk);
    wr_strobe = 1'b0;
    wr_data = ~data;
  endtask : write
  // Read-back answers one cycle after the sub-address is set.
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    sub_addr = addr;
    @(negedge clk);
    data = rd_data;
  endtask : read
endmodule : serial_master_model

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench of the preamp control register bank.
// Assumes: 200 MHz clock; the master model drives the sub-address, data and strobe, and the bench drives clock and reset.
// Notes: Expected values come from local tables, never from the bank.
`timescale 1ns/100ps
module tb_top;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  wire [7:0] SUB_ADDR, WR_DATA, RD_DATA, CONTRAST_CODE, BRIGHTNESS_CODE, MISC_CODE;
  wire [7:0] CHANNEL_ONE_CODE, CHANNEL_TWO_CODE, CHANNEL_THREE_CODE;
  wire [3:0] OUTPUT_LEVEL_CODE, OVERLAY_GAIN_CODE;
  wire [8:0] CLAMP_WIDTH_CYCLES;
  wire WR_STROBE, CLAMP_FROM_BLANKING, SOFT_BLANK_ON, SOFT_BLANK_TEST, SEMI_TRANSPARENT_ON;
  wire BLANKING_NEGATIVE, LEVEL_CODE_INVALID, WRITE_DONE, WRITE_MISSED;
  int error_cnt = 0;
  int samples_checked = 0;
  // Power-on values and a test pattern, by sub-address minus one.
  logic [7:0] rst_tab [8] = '{8'hB4, 8'hB4, 8'hB4, 8'hB4, 8'hB4, 8'h08, 8'h08, 8'h04};
  logic [7:0] wr_tab [8] = '{8'h5A, 8'h3C, 8'h81, 8'h42, 8'h18, 8'hE6, 8'hD9, 8'h04};
  logic [8:0] wid_tab [4] = '{9'h042, 9'h084, 9'h0C8, 9'h104};
  // Half period of 2.5 ns gives 200 MHz.
  always #2.5 CLOCK = ~CLOCK;
  video_preamp_control_registers video_preamp_control_registers_inst (.CLOCK(CLOCK),
    .RST_N(RST_N), .SUB_ADDR(SUB_ADDR), .WR_DATA(WR_DATA), .WR_STROBE(WR_STROBE),
    .RD_DATA(RD_DATA), .CONTRAST_CODE(CONTRAST_CODE), .BRIGHTNESS_CODE(BRIGHTNESS_CODE),
    .CHANNEL_ONE_CODE(CHANNEL_ONE_CODE), .CHANNEL_TWO_CODE(CHANNEL_TWO_CODE),
    .CHANNEL_THREE_CODE(CHANNEL_THREE_CODE), .OUTPUT_LEVEL_CODE(OUTPUT_LEVEL_CODE),
    .OVERLAY_GAIN_CODE(OVERLAY_GAIN_CODE), .MISC_CODE(MISC_CODE),
    .CLAMP_FROM_BLANKING(CLAMP_FROM_BLANKING), .CLAMP_WIDTH_CYCLES(CLAMP_WIDTH_CYCLES),
    .SOFT_BLANK_ON(SOFT_BLANK_ON), .SOFT_BLANK_TEST(SOFT_BLANK_TEST),
    .SEMI_TRANSPARENT_ON(SEMI_TRANSPARENT_ON), .BLANKING_NEGATIVE(BLANKING_NEGATIVE),
    .LEVEL_CODE_INVALID(LEVEL_CODE_INVALID), .WRITE_DONE(WRITE_DONE),
    .WRITE_MISSED(WRITE_MISSED));
  serial_master_model serial_master_model_inst (.clk(CLOCK), .rd_data(RD_DATA),
    .sub_addr(SUB_ADDR), .wr_data(WR_DATA), .wr_strobe(WR_STROBE));
  // Compares one value and counts it.
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // Power-on values on the ports and through read-back.
  task automatic test_reset();
    logic [7:0] rd;
    check("contrast", 9'(CONTRAST_CODE), 9'h0B4);
    check("clamp_width", CLAMP_WIDTH_CYCLES, 9'h0C8);
    check("clamp_src", 9'(CLAMP_FROM_BLANKING), 9'h000);
    for (int i = 0; i < 8; i++) begin
      serial_master_model_inst.read(8'(i + 1), rd);
      check("rd_reset", 9'(rd), 9'(rst_tab[i]));
    end
    $display("test_reset done");
  endtask : test_reset
  // Each sub-address loads its own register; nibble registers drop the high bits.
  task automatic test_map();
    logic [7:0] rd;
    for (int i = 0; i < 8; i++) begin
      serial_master_model_inst.write(8'(i + 1), wr_tab[i], 1'b0);
      check("done", 9'(WRITE_DONE), 9'h001);
    end
    for (int i = 0; i < 8; i++) begin
      serial_master_model_inst.read(8'(i + 1), rd);
      check("rd_map", 9'(rd), 9'((i == 5 || i == 6) ? {4'h0, wr_tab[i][3:0]} : wr_tab[i]));
    end
    check("ch2", 9'(CHANNEL_TWO_CODE), 9'h042);
    check("ch1", 9'(CHANNEL_ONE_CODE), 9'h081);
    check("ch3", 9'(CHANNEL_THREE_CODE), 9'h018);
    check("bright", 9'(BRIGHTNESS_CODE), 9'h03C);
    check("overlay", 9'(OVERLAY_GAIN_CODE), 9'h009);
    check("misc", 9'(MISC_CODE), 9'h004);
    check("level", 9'(OUTPUT_LEVEL_CODE), 9'h006);
    $display("test_map done");
  endtask : test_map
  // Unmapped sub-addresses change nothing and read as zero.
  task automatic test_unmapped();
    logic [7:0] bad [3] = '{8'h00, 8'h09, 8'hFF};
    logic [7:0] rd;
    foreach (bad[k]) begin
      serial_master_model_inst.write(bad[k], 8'h77, 1'b0);
      check("missed", 9'({WRITE_MISSED, WRITE_DONE}), 9'h002);
    end
    check("contrast_kept", 9'(CONTRAST_CODE), 9'h05A);
    serial_master_model_inst.read(8'h09, rd);
    check("rd_unmapped", 9'(rd), 9'h000);
    $display("test_unmapped done");
  endtask : test_unmapped
  // Every clamp, soft blanking, overlay and polarity setting decodes as listed.
  task automatic test_misc();
    logic [7:0] mb [7] = '{8'hC3, 8'h3A, 8'h1C, 8'h6D, 8'h86, 8'h41, 8'h04};
    foreach (mb[k]) begin
      serial_master_model_inst.write(8'h08, mb[k], 1'b0);
      repeat (2) @(negedge CLOCK);
      check("src", 9'(CLAMP_FROM_BLANKING), 9'(mb[k][0]));
      check("width", CLAMP_WIDTH_CYCLES, wid_tab[mb[k][2:1]]);
      check("soft_on", 9'(SOFT_BLANK_ON), 9'(mb[k][5:3] == 3'h7));
      check("soft_test", 9'(SOFT_BLANK_TEST), 9'(mb[k][5:3] != 3'h7 && mb[k][5:3] != 3'h0));
      check("semi", 9'(SEMI_TRANSPARENT_ON), 9'(mb[k][6]));
      check("negative", 9'(BLANKING_NEGATIVE), 9'(mb[k][7]));
    end
    $display("test_misc done");
  endtask : test_misc
  // A forbidden level code is stored and flagged; the model refuses one on its own.
  task automatic test_level();
    serial_master_model_inst.write(8'h06, 8'h02, 1'b1);
    check("bad_level", 9'({LEVEL_CODE_INVALID, OUTPUT_LEVEL_CODE}), 9'h012);
    serial_master_model_inst.write(8'h06, 8'hF3, 1'b0);
    serial_master_model_inst.write(8'h06, 8'h01, 1'b0);
    check("good_level", 9'({LEVEL_CODE_INVALID, OUTPUT_LEVEL_CODE}), 9'h003);
    $display("test_level done");
  endtask : test_level
  // Main sequence: ten cycles of reset, then each test.
  initial begin
    repeat (10) @(negedge CLOCK);
    RST_N = 1'b1;
    test_reset();
    test_map();
    test_unmapped();
    test_misc();
    test_level();
    complete_run();
  end
  // The tests need about a hundred cycles; a hang is cut well beyond that.
  initial begin
    repeat (5000) @(posedge CLOCK);
    error_cnt++;
    complete_run();
  end
endmodule : tb_top
bind video_preamp_control_registers preamp_regs_checker preamp_regs_checker_inst (
  .CLOCK(CLOCK), .RST_N(RST_N), .SUB_ADDR(SUB_ADDR), .WR_DATA(WR_DATA),
  .WR_STROBE(WR_STROBE), .CONTRAST_CODE(CONTRAST_CODE), .CHANNEL_ONE_CODE(CHANNEL_ONE_CODE),
  .CHANNEL_TWO_CODE(CHANNEL_TWO_CODE), .OUTPUT_LEVEL_CODE(OUTPUT_LEVEL_CODE),
  .OVERLAY_GAIN_CODE(OVERLAY_GAIN_CODE), .MISC_CODE(MISC_CODE),
  .CLAMP_FROM_BLANKING(CLAMP_FROM_BLANKING), .CLAMP_WIDTH_CYCLES(CLAMP_WIDTH_CYCLES),
  .SOFT_BLANK_ON(SOFT_BLANK_ON), .SEMI_TRANSPARENT_ON(SEMI_TRANSPARENT_ON),
  .BLANKING_NEGATIVE(BLANKING_NEGATIVE), .WRITE_DONE(WRITE_DONE), .WRITE_MISSED(WRITE_MISSED));
